// ==== rtl/rpos_params.svh ====
// Purpose: register map, field positions and reset values
// Assumes: 16-bit byte addresses on a 32-bit register bus
// Notes: definitions only
`ifndef RPOS_PARAMS_SVH
`define RPOS_PARAMS_SVH
`define RPOS_A_SHAPE0   16'hffb8
`define RPOS_A_SHAPE1   16'hffbc
`define RPOS_A_PCTL0    16'hff80
`define RPOS_A_PCTL1    16'hff84
`define RPOS_A_SEL0     16'hff88
`define RPOS_A_SEL1     16'hff8c
`define RPOS_A_BUFH0    16'hff90
`define RPOS_A_BUFL0    16'hff94
`define RPOS_A_BUFH1    16'hff98
`define RPOS_A_BUFL1    16'hff9c
`define RPOS_A_DIR3     16'hffa0
`define RPOS_A_LAT3     16'hffa4
`define RPOS_A_PINS     16'hffa8
`define RPOS_B_SEL      7
`define RPOS_B_PEVEN    6
`define RPOS_B_PODD     5
`define RPOS_B_INV      4
`define RPOS_B_OE       7
`define RPOS_B_EDGE     6
`define RPOS_B_WIDTH    5
`define RPOS_B_EXT      4
`define RPOS_M_SHAPE    8'hf0
`define RPOS_M_PCTL0    8'hf0
`define RPOS_M_PCTL1    8'ha0
`define RPOS_M_SEL1     8'h3f
`define RPOS_M_NIB      8'h0f
`define RPOS_M_BUFH1    8'h03
`define RPOS_M_EVEN     8'h15
`define RPOS_M_ODD      8'h2a
`define RPOS_R_ZERO     8'h00
`define RPOS_R_DIR3     8'hff
`define RPOS_RESP_OK    2'h0
`define RPOS_RESP_ERR   2'h2
`endif

// ==== rtl/rpos_pkg.sv ====
// Purpose: shared types of the pattern output shaper
// Assumes: nothing
// Notes: constants live in rpos_params.svh
package rpos_pkg;
	typedef logic [7:0] rpos_byte_t;
	typedef enum logic [1:0] {
		RPOS_SPLIT_BA = 2'h0,
		RPOS_SPLIT_AE = 2'h1,
		RPOS_BYTE_A   = 2'h2,
		RPOS_BYTE_E   = 2'h3
	} rpos_trig_t;
endpackage

// ==== rtl/rpos_shape_if.sv ====
// Purpose: carries one channel's shaping inputs and result
// Assumes: one instance per channel
// Notes: n is the pin count of the channel
`timescale 1ns/1ns
interface rpos_shape_if #(parameter int N = 8);
	logic         dcen;
	logic         inv;
	logic [N-1:0] pwm_on;
	logic [N-1:0] rt;
	logic [N-1:0] src;
	logic [N-1:0] bypass;
	logic [N-1:0] shaped;
	modport ctrl   (output dcen, inv, pwm_on, rt, src, bypass, input shaped);
	modport shaper (input dcen, inv, pwm_on, rt, src, bypass, output shaped);
endinterface

// ==== rtl/rpos_shaper.sv ====
// Purpose: per-pin inversion and pwm modulation of a pattern
// Assumes: rt already gated by enable and bit select
// Notes: purely combinational; pwm source passes straight through
`timescale 1ns/1ns
module rpos_shaper
	import rpos_pkg::*;
#(
	parameter int N = 8
)(
	rpos_shape_if.shaper s
);
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			if (!s.dcen)
				s.shaped[i] = s.bypass[i];
			else if (s.pwm_on[i])
				s.shaped[i] = s.rt[i] ? ~s.inv : s.src[i];
			else
				s.shaped[i] = s.rt[i] ^ s.inv;
		end
	end
endmodule

// ==== rtl/rpos_top.sv ====
// Purpose: real-time pattern output port with output shaping
// Assumes: trigger inputs are one-cycle strobes on aclk
// Notes: registers over axi4-lite, one byte per word
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "rpos_params.svh"
module rpos_top
	import rpos_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [15:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [15:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [7:0]  pattern_in,
	output logic [7:0]       pattern_out_pins,
	output logic [7:0]       pattern_oe_n,
	output logic [5:0]       inverter_timer_pins,
	input  wire logic [5:0]  inverter_timer_in,
	input  wire logic        pwm_source_timer_out,
	input  wire logic        compare_event_a,
	input  wire logic        compare_event_b,
	input  wire logic        compare_event_c,
	input  wire logic        ext_edge_event
);
	rpos_byte_t output_shaping_control_0;
	rpos_byte_t output_shaping_control_1;
	rpos_byte_t rt_port_control_0;
	rpos_byte_t rt_port_control_1;
	rpos_byte_t rt_bit_select_0;
	rpos_byte_t rt_bit_select_1;
	rpos_byte_t rt_buffer_high_0;
	rpos_byte_t rt_buffer_low_0;
	rpos_byte_t rt_buffer_high_1;
	rpos_byte_t rt_buffer_low_1;
	rpos_byte_t pin_direction_3;
	rpos_byte_t pin_latch_3;
	rpos_byte_t out_latch_0;
	logic [5:0] out_latch_1;
	rpos_byte_t pin_s1;
	rpos_byte_t pin_s2;
	rpos_byte_t pin_s3;
	rpos_byte_t pin_level;
	logic       wr_go;
	logic       wr_en;
	logic       wr_bad;
	rpos_byte_t wr_byte;
	rpos_byte_t next_rd;
	logic       next_rd_bad;
	rpos_trig_t trig_mode;
	logic       trig_hi;
	logic       trig_lo;
	logic       oe0;
	logic       oe1;
	rpos_byte_t pwm_on_1;

	rpos_shape_if #(.N(8)) sh0 ();
	rpos_shape_if #(.N(6)) sh1 ();

	// write channel: address and data are taken together, one write in flight
	assign wr_go   = awvalid && wvalid && !bvalid;
	assign awready = wr_go;
	assign wready  = wr_go;
	assign wr_en   = wr_go && wstrb[0];
	assign wr_byte = wdata[7:0];
	assign arready = !rvalid;

	always_comb
	begin
		case (awaddr)
			`RPOS_A_SHAPE0, `RPOS_A_SHAPE1, `RPOS_A_PCTL0, `RPOS_A_PCTL1,
			`RPOS_A_SEL0, `RPOS_A_SEL1, `RPOS_A_BUFH0, `RPOS_A_BUFL0,
			`RPOS_A_BUFH1, `RPOS_A_BUFL1, `RPOS_A_DIR3, `RPOS_A_LAT3,
			`RPOS_A_PINS: wr_bad = 1'b0;
			default:      wr_bad = 1'b1;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= `RPOS_RESP_OK;
		end
		else if (wr_go)
		begin
			bvalid <= 1'b1;
			bresp  <= wr_bad ? `RPOS_RESP_ERR : `RPOS_RESP_OK;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// shaping controls; low nibble is hardwired zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			output_shaping_control_0 <= `RPOS_R_ZERO;
			output_shaping_control_1 <= `RPOS_R_ZERO;
		end
		else if (wr_en)
		begin
			if (awaddr == `RPOS_A_SHAPE0)
				output_shaping_control_0 <= wr_byte & `RPOS_M_SHAPE;
			if (awaddr == `RPOS_A_SHAPE1)
				output_shaping_control_1 <= wr_byte & `RPOS_M_SHAPE;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rt_port_control_0 <= `RPOS_R_ZERO;
			rt_port_control_1 <= `RPOS_R_ZERO;
			rt_bit_select_0   <= `RPOS_R_ZERO;
			rt_bit_select_1   <= `RPOS_R_ZERO;
		end
		else if (wr_en)
		begin
			if (awaddr == `RPOS_A_PCTL0)
				rt_port_control_0 <= wr_byte & `RPOS_M_PCTL0;
			if (awaddr == `RPOS_A_PCTL1)
				rt_port_control_1 <= wr_byte & `RPOS_M_PCTL1;
			if (awaddr == `RPOS_A_SEL0)
				rt_bit_select_0 <= wr_byte;
			if (awaddr == `RPOS_A_SEL1)
				rt_bit_select_1 <= wr_byte & `RPOS_M_SEL1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rt_buffer_high_0 <= `RPOS_R_ZERO;
			rt_buffer_low_0  <= `RPOS_R_ZERO;
			rt_buffer_high_1 <= `RPOS_R_ZERO;
			rt_buffer_low_1  <= `RPOS_R_ZERO;
		end
		else if (wr_en)
		begin
			if (awaddr == `RPOS_A_BUFH0)
				rt_buffer_high_0 <= wr_byte & `RPOS_M_NIB;
			if (awaddr == `RPOS_A_BUFL0)
				rt_buffer_low_0 <= wr_byte & `RPOS_M_NIB;
			if (awaddr == `RPOS_A_BUFH1)
				rt_buffer_high_1 <= wr_byte & `RPOS_M_BUFH1;
			if (awaddr == `RPOS_A_BUFL1)
				rt_buffer_low_1 <= wr_byte & `RPOS_M_NIB;
		end
	end

	// port direction resets to all inputs so nothing is driven before setup
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_direction_3 <= `RPOS_R_DIR3;
			pin_latch_3     <= `RPOS_R_ZERO;
		end
		else if (wr_en)
		begin
			if (awaddr == `RPOS_A_DIR3)
				pin_direction_3 <= wr_byte;
			if (awaddr == `RPOS_A_LAT3)
				pin_latch_3 <= wr_byte;
		end
	end

	// read channel, registered answer one cycle after arvalid is taken
	always_comb
	begin
		next_rd_bad = 1'b0;
		case (araddr)
			`RPOS_A_SHAPE0: next_rd = output_shaping_control_0;
			`RPOS_A_SHAPE1: next_rd = output_shaping_control_1;
			`RPOS_A_PCTL0:  next_rd = rt_port_control_0;
			`RPOS_A_PCTL1:  next_rd = rt_port_control_1;
			`RPOS_A_SEL0:   next_rd = rt_bit_select_0;
			`RPOS_A_SEL1:   next_rd = rt_bit_select_1;
			`RPOS_A_BUFH0:  next_rd = rt_buffer_high_0 & {4'h0, rt_bit_select_0[7:4]};
			`RPOS_A_BUFL0:  next_rd = rt_buffer_low_0 & {4'h0, rt_bit_select_0[3:0]};
			`RPOS_A_BUFH1:  next_rd = rt_buffer_high_1 & {6'h00, rt_bit_select_1[5:4]};
			`RPOS_A_BUFL1:  next_rd = rt_buffer_low_1 & {4'h0, rt_bit_select_1[3:0]};
			`RPOS_A_DIR3:   next_rd = pin_direction_3;
			`RPOS_A_LAT3:   next_rd = pin_latch_3;
			`RPOS_A_PINS:   next_rd = pin_level;
			default:
			begin
				next_rd     = `RPOS_R_ZERO;
				next_rd_bad = 1'b1;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= `RPOS_RESP_OK;
		end
		else if (arvalid && !rvalid)
		begin
			rvalid <= 1'b1;
			rdata  <= {24'h0, next_rd};
			rresp  <= next_rd_bad ? `RPOS_RESP_ERR : `RPOS_RESP_OK;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	// pin readback: a level counts once the second and third stages agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_s1    <= `RPOS_R_ZERO;
			pin_s2    <= `RPOS_R_ZERO;
			pin_s3    <= `RPOS_R_ZERO;
			pin_level <= `RPOS_R_ZERO;
		end
		else
		begin
			pin_s1 <= pattern_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			for (int i = 0; i < 8; i++)
				if (pin_s2[i] == pin_s3[i])
					pin_level[i] <= pin_s3[i];
		end
	end

	// trigger selection for channel 0
	assign oe0       = rt_port_control_0[`RPOS_B_OE];
	assign oe1       = rt_port_control_1[`RPOS_B_OE];
	assign trig_mode = rpos_trig_t'({rt_port_control_0[`RPOS_B_WIDTH],
	                                 rt_port_control_0[`RPOS_B_EXT]});

	always_comb
	begin
		case (trig_mode)
			RPOS_SPLIT_BA:
			begin
				trig_hi = compare_event_b;
				trig_lo = compare_event_a;
			end
			RPOS_SPLIT_AE:
			begin
				trig_hi = compare_event_a;
				trig_lo = ext_edge_event;
			end
			RPOS_BYTE_A:
			begin
				trig_hi = compare_event_a;
				trig_lo = compare_event_a;
			end
			RPOS_BYTE_E:
			begin
				trig_hi = ext_edge_event;
				trig_lo = ext_edge_event;
			end
			default:
			begin
				trig_hi = 1'b0;
				trig_lo = 1'b0;
			end
		endcase
	end

	// a buffer written in the trigger cycle is not yet seen by that trigger
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			out_latch_0 <= `RPOS_R_ZERO;
		else if (oe0)
		begin
			if (trig_hi)
				out_latch_0[7:4] <= rt_buffer_high_0[3:0];
			if (trig_lo)
				out_latch_0[3:0] <= rt_buffer_low_0[3:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			out_latch_1 <= 6'h00;
		else if (oe1 && compare_event_c)
		begin
			out_latch_1[3:0] <= rt_buffer_low_1[3:0];
			if (rt_port_control_1[`RPOS_B_WIDTH])
				out_latch_1[5:4] <= rt_buffer_high_1[1:0];
		end
	end

	// channel 0 shaping; pwm exists only on pins 0 to 5
	assign sh0.dcen   = output_shaping_control_0[`RPOS_B_SEL];
	assign sh0.inv    = output_shaping_control_0[`RPOS_B_INV];
	assign sh0.pwm_on = (output_shaping_control_0[`RPOS_B_PEVEN] ? `RPOS_M_EVEN : 8'h00)
	                  | (output_shaping_control_0[`RPOS_B_PODD] ? `RPOS_M_ODD : 8'h00);
	assign sh0.rt     = out_latch_0 & rt_bit_select_0 & {8{oe0}};
	assign sh0.src    = {8{pwm_source_timer_out}};
	assign sh0.bypass = sh0.rt;

	rpos_shaper #(.N(8)) u_shape0 (.s(sh0.shaper));

	// channel 1 shaping
	assign sh1.dcen   = output_shaping_control_1[`RPOS_B_SEL];
	assign sh1.inv    = output_shaping_control_1[`RPOS_B_INV];
	// built at byte width so the shared pin masks apply, then cut to six pins
	assign pwm_on_1   = (output_shaping_control_1[`RPOS_B_PEVEN] ? `RPOS_M_EVEN : 8'h00)
	                  | (output_shaping_control_1[`RPOS_B_PODD] ? `RPOS_M_ODD : 8'h00);
	assign sh1.pwm_on = pwm_on_1[5:0];
	assign sh1.rt     = out_latch_1 & rt_bit_select_1[5:0] & {6{oe1}};
	assign sh1.src    = inverter_timer_in;
	assign sh1.bypass = inverter_timer_in;

	rpos_shaper #(.N(6)) u_shape1 (.s(sh1.shaper));

	// pin drivers: latch ored with pattern, direction turns the driver off
	assign pattern_out_pins    = pin_latch_3 | sh0.shaped;
	assign pattern_oe_n        = pin_direction_3;
	assign inverter_timer_pins = sh1.shaped;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence

	sequence s_resp_held;
		bvalid && !bready;
	endsequence

	a_bus_write_resp: assert property (s_wr_taken |=> bvalid)
		else $error("write not answered next cycle");
	a_bus_resp_hold: assert property (s_resp_held |=> bvalid && $stable(bresp))
		else $error("write response dropped before bready");
	a_latch_hi_copy: assert property (oe0 && trig_hi |=>
		out_latch_0[7:4] == $past(rt_buffer_high_0[3:0]))
		else $error("high nibble not copied on trigger");
	a_latch_lo_copy: assert property (oe0 && trig_lo |=>
		out_latch_0[3:0] == $past(rt_buffer_low_0[3:0]))
		else $error("low nibble not copied on trigger");
	a_latch_idle_hold: assert property (!oe0 |=> $stable(out_latch_0))
		else $error("latch moved while output disabled");
	a_ch1_copy_low: assert property (oe1 && compare_event_c |=>
		out_latch_1[3:0] == $past(rt_buffer_low_1[3:0]))
		else $error("channel 1 latch not copied");
	a_split_trig_b: assert property (oe0 && trig_mode == RPOS_SPLIT_BA && compare_event_b
		&& !compare_event_a |=> out_latch_0[3:0] == $past(out_latch_0[3:0]))
		else $error("low nibble moved on high trigger");
	a_dir_input_pin: assert property (pattern_oe_n == pin_direction_3)
		else $error("driver enable does not follow direction");
	a_latch_forces_high: assert property ((pattern_out_pins & pin_latch_3) == pin_latch_3)
		else $error("latched high pin not driven high");
	a_disabled_zero: assert property (!oe0 && !sh0.inv && pin_latch_3 == 8'h00
		&& !(sh0.dcen && sh0.pwm_on != 8'h00) |-> pattern_out_pins == 8'h00)
		else $error("disabled channel not low");
	a_inv_idle_high: assert property (sh0.dcen && sh0.inv && !oe0 && sh0.pwm_on == 8'h00
		|-> pattern_out_pins == 8'hff)
		else $error("inverted idle not high");
	a_ch1_bypass_path: assert property (!sh1.dcen |-> inverter_timer_pins == inverter_timer_in)
		else $error("timer outputs not routed through");
	a_buf_read_mask: assert property (arvalid && arready && araddr == `RPOS_A_BUFL0 |=>
		(rdata[3:0] & ~$past(rt_bit_select_0[3:0])) == 4'h0)
		else $error("unselected buffer bit read back");
endmodule

// ==== dv/rpos_load.sv ====
// Purpose: outside loads and drivers on the channel 0 pins
// Assumes: drive is what outside parts force onto released pins
// Notes: a released pin shows the outside level, never the last driven one
`timescale 1ns/1ns
module rpos_load
(
	input  wire logic [7:0] pins,
	input  wire logic [7:0] oe_n,
	input  wire logic [7:0] drive,
	output logic [7:0]      level
);
	always_comb
		for (int i = 0; i < 8; i++)
			level[i] = oe_n[i] ? drive[i] : pins[i];
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the pattern output shaper
// Assumes: axi4-lite master with one request at a time
// Notes: expected pins come from the pin tables, not from the rtl
`timescale 1ns/1ns
`include "rpos_params.svh"
module tb;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [15:0] awaddr = 0;
	logic [15:0] araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0]  wstrb = 0;
	logic [3:0]  ev = 0;
	logic        awvalid = 0;
	logic        wvalid = 0;
	logic        arvalid = 0;
	// responses are never stalled, so ready stays high
	logic        bready = 1;
	logic        rready = 1;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [7:0]  pin, oe_n, pin_in, lat0;
	logic [7:0]  ext = 8'ha5;
	logic [5:0]  tpin;
	logic [5:0]  tmr = 6'h2d;
	logic        pwm = 0;
	int          bad_count = 0;
	int          comparisons = 0;
	always #10 aclk = ~aclk;
	rpos_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.pattern_in(pin_in), .pattern_out_pins(pin), .pattern_oe_n(oe_n),
		.inverter_timer_pins(tpin), .inverter_timer_in(tmr), .pwm_source_timer_out(pwm),
		.compare_event_a(ev[0]), .compare_event_b(ev[1]), .ext_edge_event(ev[2]),
		.compare_event_c(ev[3]));
	rpos_load load (.pins(pin), .oe_n(oe_n), .drive(ext), .level(pin_in));
	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hang(input int n);
		if (n >= 64)
		begin
			bad_count++;
			$display("BAD handshake expected answer seen none");
			wrap_up();
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0,
		input logic [3:0] st = 4'hf);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (!(awready === 1'b1 && wready === 1'b1) && n < 64);
		hang(n);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (bvalid !== 1'b1 && n < 64);
		hang(n);
		chk("bresp", bresp, er);
		#1;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er = 2'h0);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (arready !== 1'b1 && n < 64);
		hang(n);
		arvalid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (rvalid !== 1'b1 && n < 64);
		hang(n);
		chk($sformatf("reg %h", a), rdata, {24'h0, e});
		chk("rresp", rresp, er);
		#1;
	endtask
	task automatic fire(input int i);
		ev[i] <= 1'b1;
		@(posedge aclk);
		ev[i] <= 1'b0;
		#1;
	endtask
	// pin table: off passes off, pwm pins pass src unless the bit is set
	function automatic logic [7:0] ref_pin(input logic [7:0] rt, input logic [7:0] c,
		input logic [7:0] src, input logic [7:0] off);
		logic [7:0] y;
		logic       p;
		y = off;
		if (c[7])
			for (int i = 0; i < 8; i++)
			begin
				p = (i < 6) && (i[0] ? c[5] : c[6]);
				y[i] = p ? (rt[i] ? ~c[4] : src[i]) : rt[i] ^ c[4];
			end
		return y;
	endfunction
	task automatic t_reset;
		rchk(`RPOS_A_SHAPE0, 8'h00);
		rchk(`RPOS_A_SHAPE1, 8'h00);
		rchk(`RPOS_A_DIR3, 8'hff);
		chk("oe_n", oe_n, 8'hff);
		chk("pins", pin, 8'h00);
		chk("tpins", tpin, tmr);
		rchk(16'hff00, 8'h00, `RPOS_RESP_ERR);
		wr(16'hff00, 8'h55, `RPOS_RESP_ERR);
		// lane 0 strobe low: answered but nothing stored
		wr(`RPOS_A_SHAPE0, 8'hff, `RPOS_RESP_OK, 4'h0);
		rchk(`RPOS_A_SHAPE0, 8'h00);
		wr(`RPOS_A_SHAPE0, 8'hff);
		rchk(`RPOS_A_SHAPE0, 8'hf0);
		wr(`RPOS_A_SHAPE1, 8'hff);
		rchk(`RPOS_A_SHAPE1, 8'hf0);
		wr(`RPOS_A_SHAPE0, 8'h00);
		wr(`RPOS_A_SHAPE1, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_trig;
		int hi_t [4] = '{1, 0, 0, 2};
		int lo_t [4] = '{0, 2, 0, 2};
		wr(`RPOS_A_DIR3, 8'h00);
		wr(`RPOS_A_SEL0, 8'hff);
		lat0 = 8'h00;
		for (int m = 0; m < 4; m++)
		begin
			wr(`RPOS_A_PCTL0, 8'h80 | 8'(m << 4));
			for (int t = 0; t < 3; t++)
			begin
				wr(`RPOS_A_BUFH0, 8'(4 * m + t + 1));
				wr(`RPOS_A_BUFL0, 8'(15 - 4 * m - t));
				fire(t);
				if (hi_t[m] == t)
					lat0[7:4] = 4'(4 * m + t + 1);
				if (lo_t[m] == t)
					lat0[3:0] = 4'(15 - 4 * m - t);
				chk("trig", pin, lat0);
			end
		end
		$display("test trigger done");
	endtask
	task automatic t_gate;
		wr(`RPOS_A_PCTL0, 8'h20);
		chk("off", pin, 8'h00);
		wr(`RPOS_A_SHAPE0, 8'h90);
		chk("inv off", pin, 8'hff);
		wr(`RPOS_A_SHAPE0, 8'h00);
		wr(`RPOS_A_BUFH0, 8'h03);
		wr(`RPOS_A_BUFL0, 8'h0c);
		fire(0);
		wr(`RPOS_A_PCTL0, 8'ha0);
		chk("hold", pin, lat0);
		wr(`RPOS_A_SEL0, 8'h0f);
		chk("sel", pin, {4'h0, lat0[3:0]});
		rchk(`RPOS_A_BUFH0, 8'h00);
		rchk(`RPOS_A_BUFL0, 8'h0c);
		wr(`RPOS_A_SEL0, 8'h05);
		rchk(`RPOS_A_BUFL0, 8'h04);
		wr(`RPOS_A_SEL0, 8'hff);
		$display("test gate done");
	endtask
	task automatic t_shape0;
		wr(`RPOS_A_BUFH0, 8'h05);
		wr(`RPOS_A_BUFL0, 8'h0a);
		fire(0);
		lat0 = 8'h5a;
		for (int s = 0; s < 16; s++)
		begin
			wr(`RPOS_A_SHAPE0, 8'(s << 4));
			for (int p = 0; p < 2; p++)
			begin
				pwm <= p[0];
				@(posedge aclk);
				#1;
				chk("shape0", pin, ref_pin(lat0, 8'(s << 4), {8{p[0]}}, lat0));
			end
		end
		wr(`RPOS_A_LAT3, 8'h81);
		chk("latch", pin, 8'h81 | ref_pin(lat0, 8'hf0, 8'hff, lat0));
		wr(`RPOS_A_LAT3, 8'h00);
		wr(`RPOS_A_SHAPE0, 8'h00);
		wr(`RPOS_A_DIR3, 8'hf0);
		chk("dir", oe_n, 8'hf0);
		// three sampling flops and the level register on the pin path
		repeat (4) @(posedge aclk);
		rchk(`RPOS_A_PINS, {ext[7:4], lat0[3:0]});
		$display("test shape0 done");
	endtask
	task automatic t_ch1;
		wr(`RPOS_A_SEL1, 8'h3f);
		wr(`RPOS_A_BUFL1, 8'h09);
		wr(`RPOS_A_BUFH1, 8'h02);
		wr(`RPOS_A_PCTL1, 8'h80);
		fire(3);
		chk("tmr", tpin, tmr);
		wr(`RPOS_A_SHAPE1, 8'h80);
		chk("w4", tpin, 6'h09);
		wr(`RPOS_A_PCTL1, 8'ha0);
		fire(3);
		chk("w6", tpin, 6'h29);
		for (int s = 0; s < 16; s++)
		begin
			wr(`RPOS_A_SHAPE1, 8'(s << 4));
			for (int k = 0; k < 2; k++)
			begin
				tmr <= k[0] ? 6'h12 : 6'h2d;
				@(posedge aclk);
				#1;
				chk("shape1", tpin, 6'(ref_pin(8'h29, 8'(s << 4), {2'h0, tmr}, {2'h0, tmr})));
			end
		end
		wr(`RPOS_A_SEL1, 8'h25);
		rchk(`RPOS_A_BUFL1, 8'h01);
		rchk(`RPOS_A_BUFH1, 8'h02);
		$display("test ch1 done");
	endtask
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		t_reset();
		t_trig();
		t_gate();
		t_shape0();
		t_ch1();
		wrap_up();
	end
endmodule
